// >>> common/mmd_pkg.sv
// memory map decoder constants: window bounds, register addresses, reset values
// assumes a 16-bit byte address in both code and data space and 8-bit data
package mmd_pkg;

    // peripheral register windows in data space
    localparam logic [15:0] SFR1_LO = 16'h0000;
    localparam logic [15:0] SFR1_HI = 16'h003F;
    localparam logic [15:0] SFR2_LO = 16'h0F00;
    localparam logic [15:0] SFR2_HI = 16'h0FFF;
    localparam logic [15:0] SFR3_LO = 16'h0E40;
    localparam logic [15:0] SFR3_HI = 16'h0EFF;

    // on-chip ram in data space
    localparam logic [15:0] RAM_LO = 16'h0040;
    localparam logic [15:0] RAM_HI = 16'h083F;

    // boot rom window; serial prom mode opens the whole boot rom
    localparam logic [15:0] BOOT_LO = 16'h1000;
    localparam logic [15:0] BOOT_HI = 16'h17FF;
    localparam logic [15:0] BOOT_SP_HI = 16'h1FFF;
    localparam int BOOT_AW = 12;

    // flash array in both spaces
    localparam logic [15:0] FLASH_LO = 16'h8000;
    localparam int FLASH_AW = 15;
    localparam int RAM_AW = 11;

    // own registers inside the second peripheral window
    localparam logic [15:0] CFG_ADDR = 16'h0FD0;
    localparam logic [15:0] KEY_ADDR = 16'h0FD1;
    localparam logic [15:0] MON_ADDR = 16'h0FD2;

    localparam logic [7:0] CFG_RST = 8'h40;
    localparam int BOOT_MAP_BIT = 4;
    localparam logic [7:0] KEY_VALUE = 8'hD5;
    localparam logic [7:0] OPEN_BUS = 8'hFF;
    localparam logic [7:0] WO_READ = 8'h00;

    typedef enum logic [2:0] {
        REG_NONE,
        REG_SFR,
        REG_RAM,
        REG_BOOT,
        REG_FLASH
    } mmd_region_t;

endpackage : mmd_pkg

// >>> hdl/mmd_sync3.sv
// three-stage synchroniser for one level from outside the clock domain
// assumes the level is slow against clk_i; output moves once stages 2 and 3 agree
`timescale 1ns/100ps
module mmd_sync3 (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // async reset, active high
    input wire logic d_i,   // asynchronous level
    output logic q_o        // filtered synchronous level
);

    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic level_q;
    logic level_d;

    always_comb
    begin
        stage_d = {stage_q[1:0], d_i};
        level_d = level_q;
        if (stage_q[1] == stage_q[2])
        begin
            level_d = stage_q[2];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            stage_q <= 3'h0;
            level_q <= 1'b0;
        end
        else
        begin
            stage_q <= stage_d;
            level_q <= level_d;
        end
    end

    assign q_o = level_q;

endmodule : mmd_sync3

// >>> hdl/mmd_space_dec.sv
// region decode of one 16-bit address in code or data space
// assumes the boot map bit is the active (applied) value, not the pending one
`timescale 1ns/100ps
module mmd_space_dec #(
    parameter bit IS_DATA = 1'b0 // 1: data space, 0: code space
) (
    input wire logic [15:0] addr_i,       // byte address
    input wire logic boot_map_i,          // boot rom mapped
    input wire logic serial_prom_i,       // serial prom mode
    output mmd_pkg::mmd_region_t region_o // decoded target
);

    logic in_boot;
    logic [15:0] boot_hi;

    always_comb
    begin
        boot_hi = serial_prom_i ? mmd_pkg::BOOT_SP_HI : mmd_pkg::BOOT_HI; // R08
        in_boot = (addr_i >= mmd_pkg::BOOT_LO) && (addr_i <= boot_hi);
        region_o = mmd_pkg::REG_NONE;
        if (addr_i >= mmd_pkg::FLASH_LO)
        begin
            region_o = mmd_pkg::REG_FLASH; // R09 R10
        end
        else if (in_boot)
        begin
            // hole when unmapped
            region_o = boot_map_i ? mmd_pkg::REG_BOOT : mmd_pkg::REG_NONE; // R01 R02
        end
        else if (IS_DATA)
        begin
            if ((addr_i <= mmd_pkg::SFR1_HI)
                || ((addr_i >= mmd_pkg::SFR2_LO) && (addr_i <= mmd_pkg::SFR2_HI))
                || ((addr_i >= mmd_pkg::SFR3_LO) && (addr_i <= mmd_pkg::SFR3_HI)))
            begin
                region_o = mmd_pkg::REG_SFR; // R11
            end
            else if ((addr_i >= mmd_pkg::RAM_LO) && (addr_i <= mmd_pkg::RAM_HI))
            begin
                region_o = mmd_pkg::REG_RAM; // R12
            end
        end
    end

endmodule : mmd_space_dec

// >>> hdl/mmd_decoder.sv
// code and data space decoder with the boot rom map configuration registers
// assumes targets return read data combinationally in the cycle of the access
// and that the cpu holds address and strobes stable for that one cycle
// What this block does
// R01: with the active boot map bit set, 0x1000-0x17FF of both spaces go to the boot rom.
// R02: with the active boot map bit clear, that range of neither space goes to the boot rom.
// R03: after reset the boot rom is mapped in neither space until software applies it.
// R04: config writes land in a pending copy that becomes active only on key byte 0xD5.
// R05: the active copy of the map config is readable at a separate monitor address.
// R06: the key register acts only on 0xD5; every other value is reserved.
// R07: data reads of 0x1000-0x17FF while the boot rom is unmapped return 0xFF.
// R08: outside serial prom mode only the first 2 Kbytes of boot rom are visible.
// R09: code addresses 0x8000-0xFFFF go to flash from reset onward.
// R10: data addresses 0x8000-0xFFFF go to flash from reset onward.
// R11: data windows 0x0000-0x003F, 0x0F00-0x0FFF and 0x0E40-0x0EFF go to the registers.
// R12: data addresses 0x0040-0x083F go to the on-chip ram from reset onward.
// R13: software must not touch reserved locations inside the register windows.
// R14: a non-key write to the key register changes neither active copy nor decoding.
// R15: reading the config register returns the last written pending value.
`timescale 1ns/100ps
module mmd_decoder (
    input wire logic clk_i,                     // system clock, 25 MHz
    input wire logic rst_i,                     // async reset, active high
    input wire logic serial_prom_i,             // serial prom mode pin

    input wire logic code_fetch_i,              // code fetch strobe
    input wire logic [15:0] code_addr_i,        // code fetch address
    output logic code_flash_sel_o,              // fetch goes to flash
    output logic code_boot_sel_o,               // fetch goes to boot rom
    output logic code_hole_o,                   // fetch hits nothing mapped
    output logic [14:0] code_flash_addr_o,      // flash byte offset
    output logic [11:0] code_boot_addr_o,       // boot rom byte offset

    input wire logic data_rd_i,                 // data read strobe
    input wire logic data_wr_i,                 // data write strobe
    input wire logic [15:0] data_addr_i,        // data address
    input wire logic [7:0] data_wdata_i,        // data write byte
    output logic [7:0] data_rdata_o,            // read byte, one cycle later

    output logic data_sfr_sel_o,                // access to peripheral registers
    output logic data_ram_sel_o,                // access to on-chip ram
    output logic data_boot_sel_o,               // read from boot rom
    output logic data_flash_sel_o,              // access to flash
    output logic [10:0] data_ram_addr_o,        // ram byte offset
    output logic [11:0] data_boot_addr_o,       // boot rom byte offset
    output logic [14:0] data_flash_addr_o,      // flash byte offset

    input wire logic [7:0] sfr_rdata_i,         // peripheral read byte
    input wire logic [7:0] ram_rdata_i,         // ram read byte
    input wire logic [7:0] boot_rdata_i,        // boot rom read byte
    input wire logic [7:0] flash_rdata_i,       // flash read byte

    output logic boot_map_o                     // active boot map bit
);

    logic prom_mode;
    mmd_pkg::mmd_region_t code_region;
    mmd_pkg::mmd_region_t data_region;

    logic [7:0] cfg_pend_q;
    logic [7:0] cfg_pend_d;
    logic [7:0] cfg_act_q;
    logic [7:0] cfg_act_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    logic hit_cfg;
    logic hit_key;
    logic hit_mon;
    logic own_reg;
    logic cfg_wr;
    logic key_apply;
    logic boot_map;
    logic [15:0] ram_off;
    logic [15:0] boot_off;

    // the prom pin is asynchronous; filter it before it widens the boot window
    mmd_sync3 u_prom_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(serial_prom_i),
        .q_o(prom_mode)
    );

    // decoding follows only the active copy, never the pending one
    assign boot_map = cfg_act_q[mmd_pkg::BOOT_MAP_BIT]; // R01 R02 R04

    mmd_space_dec #(
        .IS_DATA(1'b0)
    ) u_code_dec (
        .addr_i(code_addr_i),
        .boot_map_i(boot_map),
        .serial_prom_i(prom_mode),
        .region_o(code_region)
    );

    mmd_space_dec #(
        .IS_DATA(1'b1)
    ) u_data_dec (
        .addr_i(data_addr_i),
        .boot_map_i(boot_map),
        .serial_prom_i(prom_mode),
        .region_o(data_region)
    );

    // own registers are carved out of the peripheral window
    always_comb
    begin
        hit_cfg = (data_addr_i == mmd_pkg::CFG_ADDR);
        hit_key = (data_addr_i == mmd_pkg::KEY_ADDR);
        hit_mon = (data_addr_i == mmd_pkg::MON_ADDR);
        own_reg = hit_cfg || hit_key || hit_mon;
        cfg_wr = data_wr_i && hit_cfg;
        key_apply = data_wr_i && hit_key && (data_wdata_i == mmd_pkg::KEY_VALUE); // R06 R14
    end

    // offsets into each target
    always_comb
    begin
        ram_off = data_addr_i - mmd_pkg::RAM_LO;
        boot_off = data_addr_i - mmd_pkg::BOOT_LO;
        data_ram_addr_o = ram_off[10:0];
        data_boot_addr_o = boot_off[11:0];
        data_flash_addr_o = data_addr_i[14:0];
        code_flash_addr_o = code_addr_i[14:0];
    end

    // code fetch boot offset; upper half only reachable in serial prom mode
    always_comb
    begin
        code_boot_addr_o = {prom_mode & code_addr_i[11], code_addr_i[10:0]}; // R08
    end

    // code space selects
    always_comb
    begin
        code_flash_sel_o = 1'b0;
        code_boot_sel_o = 1'b0;
        code_hole_o = 1'b0;
        if (code_fetch_i)
        begin
            unique case (code_region)
                mmd_pkg::REG_FLASH:
                begin
                    code_flash_sel_o = 1'b1; // R09
                end
                mmd_pkg::REG_BOOT:
                begin
                    code_boot_sel_o = 1'b1; // R01
                end
                // unmapped boot window and the rest of code space below flash
                default:
                begin
                    code_hole_o = 1'b1; // R02 R03
                end
            endcase
        end
    end

    // data space selects; the boot rom takes reads only
    always_comb
    begin
        data_sfr_sel_o = 1'b0;
        data_ram_sel_o = 1'b0;
        data_boot_sel_o = 1'b0;
        data_flash_sel_o = 1'b0;
        // writes to the boot window or to a hole select nothing
        if (data_rd_i || data_wr_i)
        begin
            unique case (data_region)
                mmd_pkg::REG_SFR:
                begin
                    data_sfr_sel_o = !own_reg; // R11
                end
                mmd_pkg::REG_RAM:
                begin
                    data_ram_sel_o = 1'b1; // R12
                end
                mmd_pkg::REG_BOOT:
                begin
                    data_boot_sel_o = data_rd_i; // R01
                end
                mmd_pkg::REG_FLASH:
                begin
                    data_flash_sel_o = 1'b1; // R10
                end
                default:
                begin
                    data_sfr_sel_o = 1'b0; // R02
                end
            endcase
        end
    end

    // pending stage: every write to the config address lands here
    always_comb
    begin
        cfg_pend_d = cfg_pend_q;
        if (cfg_wr)
        begin
            cfg_pend_d = data_wdata_i; // R04 R15
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_pend_q <= mmd_pkg::CFG_RST;
        end
        else
        begin
            cfg_pend_q <= cfg_pend_d;
        end
    end

    // active stage: only the key byte moves the pending value across
    always_comb
    begin
        cfg_act_d = cfg_act_q;
        if (key_apply)
        begin
            // the copy takes the pending value held before this cycle
            cfg_act_d = cfg_pend_q; // R04 R06
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_act_q <= mmd_pkg::CFG_RST; // R03
        end
        else
        begin
            cfg_act_q <= cfg_act_d;
        end
    end

    // registered read data
    always_comb
    begin
        rdata_d = rdata_q;
        if (data_rd_i)
        begin
            unique case (data_region)
                mmd_pkg::REG_SFR:
                begin
                    if (hit_cfg)
                    begin
                        rdata_d = cfg_pend_q; // R15
                    end
                    else if (hit_mon)
                    begin
                        rdata_d = cfg_act_q; // R05
                    end
                    else if (hit_key)
                    begin
                        // the key register is write-only and reads back as zero
                        rdata_d = mmd_pkg::WO_READ;
                    end
                    else
                    begin
                        rdata_d = sfr_rdata_i;
                    end
                end
                mmd_pkg::REG_RAM:
                begin
                    rdata_d = ram_rdata_i;
                end
                mmd_pkg::REG_BOOT:
                begin
                    rdata_d = boot_rdata_i;
                end
                mmd_pkg::REG_FLASH:
                begin
                    rdata_d = flash_rdata_i;
                end
                default:
                begin
                    rdata_d = mmd_pkg::OPEN_BUS; // R07
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_q <= mmd_pkg::OPEN_BUS;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign data_rdata_o = rdata_q;
    assign boot_map_o = boot_map;

endmodule : mmd_decoder

// >>> test/mmd_target_model.sv
// targets behind the decoder: address-derived bytes, inverse when unselected
// assumes the decoder samples read data combinationally in the read cycle
`timescale 1ns/100ps
module mmd_target_model (
    input wire logic [7:0] addr_i,       // data address low byte
    input wire logic sfr_sel_i,          // register select
    input wire logic ram_sel_i,          // ram select
    input wire logic [7:0] ram_lo_i,     // ram offset low byte
    input wire logic boot_sel_i,         // boot rom select
    input wire logic [7:0] boot_lo_i,    // boot offset low byte
    input wire logic flash_sel_i,        // flash select
    input wire logic [7:0] flash_lo_i,   // flash offset low byte
    output logic [7:0] sfr_rdata_o,      // register byte
    output logic [7:0] ram_rdata_o,      // ram byte
    output logic [7:0] boot_rdata_o,     // boot byte
    output logic [7:0] flash_rdata_o     // flash byte
);
    // every register offset answers as an implemented location
    assign sfr_rdata_o = sfr_sel_i ? addr_i ^ 8'h5A : ~(addr_i ^ 8'h5A);
    assign ram_rdata_o = ram_sel_i ? ram_lo_i ^ 8'h3C : ~(ram_lo_i ^ 8'h3C);
    assign boot_rdata_o = boot_sel_i ? boot_lo_i ^ 8'hA5 : ~(boot_lo_i ^ 8'hA5);
    assign flash_rdata_o = flash_sel_i ? flash_lo_i ^ 8'h96 : ~(flash_lo_i ^ 8'h96);
endmodule : mmd_target_model

// >>> test/mmd_decoder_checker.sv
// port assertions for mmd_decoder
// assumes one clock domain and the bind at the foot
`timescale 1ns/100ps
module mmd_decoder_checker (
    input wire logic clk_i,                   // clock
    input wire logic rst_i,                   // reset
    input wire logic serial_prom_i,           // prom mode
    input wire logic code_fetch_i,            // fetch
    input wire logic [15:0] code_addr_i,      // fetch address
    input wire logic code_flash_sel_o,        // fetch to flash
    input wire logic code_boot_sel_o,         // fetch to boot
    input wire logic [14:0] code_flash_addr_o, // flash offset
    input wire logic data_rd_i,               // read
    input wire logic data_wr_i,               // write
    input wire logic [15:0] data_addr_i,      // data address
    input wire logic [7:0] data_wdata_i,      // write byte
    input wire logic [7:0] data_rdata_o,      // read byte
    input wire logic data_sfr_sel_o,          // register select
    input wire logic data_ram_sel_o,          // ram select
    input wire logic [10:0] data_ram_addr_o,  // ram offset
    input wire logic boot_map_o               // active map bit
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff rst_i;
    wire dacc = data_rd_i | data_wr_i;
    wire in_boot = data_addr_i[15:11] == 5'h02;
    wire key_ok = data_wr_i && data_addr_i == 16'h0FD1 && data_wdata_i == 8'hD5;
    wire sfr = data_addr_i <= 16'h003F || (data_addr_i >= 16'h0E40 && data_addr_i <= 16'h0FFF);
    wire own = data_addr_i >= 16'h0FD0 && data_addr_i <= 16'h0FD2;
    sequence s_cfg_key;
        data_wr_i && data_addr_i == 16'h0FD0 ##1 key_ok;
    endsequence
    AST_BOOT_CODE:
    assert property (code_fetch_i && code_addr_i[15:11] == 5'h02 |-> code_boot_sel_o == boot_map_o)
        else $error("code boot select disagrees with map bit");
    AST_KEY_APPLY:
    assert property (s_cfg_key |=> boot_map_o == $past(data_wdata_i[4], 2))
        else $error("key did not apply pending map bit");
    AST_MAP_HOLD:
    assert property ($changed(boot_map_o) |-> $past(key_ok))
        else $error("map bit moved without key");
    AST_RESET_OFF:
    assert property ($fell(rst_i) |-> !boot_map_o)
        else $error("boot rom mapped after reset");
    AST_HOLE_FF:
    assert property (data_rd_i && in_boot && !boot_map_o |=> data_rdata_o == 8'hFF)
        else $error("unmapped boot window not read as ff");
    AST_BOOT_2K:
    assert property (code_fetch_i && code_addr_i[15:11] == 5'h03 && !serial_prom_i
        && !$past(serial_prom_i) && !$past(serial_prom_i, 2) && !$past(serial_prom_i, 3)
        && !$past(serial_prom_i, 4) |-> !code_boot_sel_o)
        else $error("boot rom above 2k visible");
    AST_FLASH_CODE:
    assert property (code_fetch_i && code_addr_i[15]
        |-> code_flash_sel_o && code_flash_addr_o == code_addr_i[14:0])
        else $error("code flash decode wrong");
    AST_SFR:
    assert property (dacc && sfr && !own |-> data_sfr_sel_o)
        else $error("register window not selected");
    AST_RAM:
    assert property (dacc && data_addr_i >= 16'h0040 && data_addr_i <= 16'h083F
        |-> data_ram_sel_o && data_ram_addr_o == 11'(data_addr_i - 16'h0040))
        else $error("ram decode wrong");
endmodule : mmd_decoder_checker

bind mmd_decoder mmd_decoder_checker u_mmd_decoder_checker (.clk_i, .rst_i, .serial_prom_i,
    .code_fetch_i, .code_addr_i, .code_flash_sel_o, .code_boot_sel_o, .code_flash_addr_o,
    .data_rd_i, .data_wr_i, .data_addr_i, .data_wdata_i, .data_rdata_o, .data_sfr_sel_o,
    .data_ram_sel_o, .data_ram_addr_o, .boot_map_o);

// >>> test/test_mmd_decoder.sv
// self-checking bench for mmd_decoder against a behavioural map model
// assumes mmd_target_model stands in for the memories and registers
`timescale 1ns/100ps
module test_mmd_decoder;
    logic clk_i = 1'h0, rst_i = 1'h1, code_fetch_i = 1'h0, data_rd_i = 1'h0, data_wr_i = 1'h0;
    logic [15:0] code_addr_i = 16'h0000, data_addr_i = 16'h0000;
    logic [7:0] data_wdata_i = 8'h00, data_rdata_o, sfr_rdata_i, ram_rdata_i;
    logic [7:0] boot_rdata_i, flash_rdata_i;
    logic code_flash_sel_o, code_boot_sel_o, code_hole_o, data_sfr_sel_o, data_ram_sel_o;
    logic data_boot_sel_o, data_flash_sel_o, boot_map_o;
    logic [14:0] code_flash_addr_o, data_flash_addr_o;
    logic [11:0] code_boot_addr_o, data_boot_addr_o;
    logic [10:0] data_ram_addr_o;
    logic [31:0] r;
    logic serial_prom_i = 1'h0, prom = 1'h0;
    wire [3:0] data_sels = {data_sfr_sel_o, data_ram_sel_o, data_boot_sel_o, data_flash_sel_o};
    integer bad_count = 0, comparisons = 0, seed = 35, pend = 'h40, act = 'h40, i;

    mmd_decoder u_mmd_decoder (.clk_i, .rst_i, .serial_prom_i, .code_fetch_i,
        .code_addr_i, .code_flash_sel_o, .code_boot_sel_o, .code_hole_o, .code_flash_addr_o,
        .code_boot_addr_o, .data_rd_i, .data_wr_i, .data_addr_i, .data_wdata_i, .data_rdata_o,
        .data_sfr_sel_o, .data_ram_sel_o, .data_boot_sel_o, .data_flash_sel_o, .data_ram_addr_o,
        .data_boot_addr_o, .data_flash_addr_o, .sfr_rdata_i, .ram_rdata_i, .boot_rdata_i,
        .flash_rdata_i, .boot_map_o);
    mmd_target_model u_mmd_target_model (.addr_i(data_addr_i[7:0]), .sfr_sel_i(data_sfr_sel_o),
        .ram_sel_i(data_ram_sel_o), .ram_lo_i(data_ram_addr_o[7:0]), .boot_sel_i(data_boot_sel_o),
        .boot_lo_i(data_boot_addr_o[7:0]), .flash_sel_i(data_flash_sel_o),
        .flash_lo_i(data_flash_addr_o[7:0]), .sfr_rdata_o(sfr_rdata_i),
        .ram_rdata_o(ram_rdata_i), .boot_rdata_o(boot_rdata_i), .flash_rdata_o(flash_rdata_i));

    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [7:0] exp_rd(input logic [15:0] a);
        logic [15:0] o;
        o = a - 16'h0040;
        if (a == 16'h0FD0) return pend[7:0];
        if (a == 16'h0FD1) return 8'h00;
        if (a == 16'h0FD2) return act[7:0];
        if (a <= 16'h003F || (a >= 16'h0E40 && a <= 16'h0FFF)) return a[7:0] ^ 8'h5A;
        if (a <= 16'h083F) return o[7:0] ^ 8'h3C;
        if (a[15]) return a[7:0] ^ 8'h96;
        if (a[15:12] == 4'h1 && (prom || !a[11]) && act[4]) return a[7:0] ^ 8'hA5;
        return 8'hFF;
    endfunction : exp_rd

    // expected {register, ram, boot, flash} selects of one data access
    function automatic logic [3:0] exp_sel(input logic wr, input logic [15:0] a);
        if (a[15]) return 4'h1;
        if (a[15:12] == 4'h1 && (prom || !a[11])) return {2'h0, act[4] & ~wr, 1'h0};
        if (a >= 16'h0FD0 && a <= 16'h0FD2) return 4'h0;
        if (a <= 16'h003F || (a >= 16'h0E40 && a <= 16'h0FFF)) return 4'h8;
        if (a >= 16'h0040 && a <= 16'h083F) return 4'h4;
        return 4'h0;
    endfunction : exp_sel

    // one access cycle entered at a falling edge, with a random fetch beside it
    task automatic op(input logic wr, input logic [15:0] a, input logic [7:0] d);
        logic [15:0] ca;
        logic f;
        logic bw;
        ca = 16'($random(seed));
        f = 1'($random(seed));
        bw = (ca[15:12] == 4'h1) && (prom || !ca[11]);
        data_wr_i = wr;
        data_rd_i = ~wr;
        data_addr_i = a;
        data_wdata_i = d;
        code_fetch_i = f;
        code_addr_i = ca;
        #1;
        chk("code flash sel", code_flash_sel_o, f & ca[15]);
        chk("code boot sel", code_boot_sel_o, f & act[4] & bw);
        chk("code hole", code_hole_o, f & ~ca[15] & ~(act[4] & bw));
        chk("code flash addr", code_flash_addr_o, ca[14:0]);
        chk("code boot addr", code_boot_addr_o, {prom & ca[11], ca[10:0]});
        chk("data sel", data_sels, exp_sel(wr, a));
        @(negedge clk_i);
        if (wr && a == 16'h0FD0) pend = d;
        if (wr && a == 16'h0FD1 && d == 8'hD5) act = pend;
        chk("map bit", boot_map_o, act[4]);
        if (!wr) chk("read data", data_rdata_o, exp_rd(a));
    endtask : op

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    initial
    begin
        #100000;
        bad_count++;
        finish_test;
    end

    initial
    begin
        repeat (8) @(negedge clk_i);
        rst_i = 1'h0;
        op(1'h0, 16'h0FD2, 8'h00);
        op(1'h0, 16'h1000, 8'h00);
        op(1'h1, 16'h0FD0, 8'h10);
        op(1'h0, 16'h0FD0, 8'h00);
        op(1'h0, 16'h17FF, 8'h00);
        for (i = 0; i < 256; i++)
            if (i != 'hD5)
                op(1'h1, 16'h0FD1, i[7:0]);
        op(1'h1, 16'h0FD1, 8'hD5);
        op(1'h0, 16'h0FD2, 8'h00);
        op(1'h0, 16'h1234, 8'h00);
        op(1'h0, 16'h1800, 8'h00);
        op(1'h1, 16'h0FD0, 8'h00);
        op(1'h1, 16'h0FD1, 8'hD5);
        op(1'h0, 16'h1000, 8'h00);
        for (i = 0; i < 400; i++)
        begin
            r = $random(seed);
            case (r[1:0])
                2'h0: op(1'h1, 16'h0FD0, r[15:8]);
                2'h1: op(1'h1, 16'h0FD1, r[4] ? 8'hD5 : r[15:8]);
                default: op(1'h0, r[5] ? {4'h1, r[27:16]} : r[31:16], 8'h00);
            endcase
        end
        op(1'h1, 16'h0FD0, 8'h10);
        op(1'h1, 16'h0FD1, 8'hD5);
        serial_prom_i = 1'h1;
        repeat (4) @(negedge clk_i);
        prom = 1'h1;
        op(1'h0, 16'h1800, 8'h00);
        op(1'h0, 16'h1FFF, 8'h00);
        rst_i = 1'h1;
        serial_prom_i = 1'h0;
        prom = 1'h0;
        pend = 'h40;
        act = 'h40;
        @(negedge clk_i);
        rst_i = 1'h0;
        op(1'h0, 16'h0FD2, 8'h00);
        data_rd_i = 1'h0;
        finish_test;
    end
endmodule : test_mmd_decoder
